//--- rtl/mbm_params.svh
/*
  Constants for the mailbox and Port B bus-matching read block: register
  offsets, field positions, reset values and lane widths.
  Assumes it is included by bare name after the package mbm_pkg.
*/
// Overview of operation
// RULE1: Two 36-bit mail registers, one each direction.
// RULE2: Mail select steers each transfer to mail/FIFO.
// RULE3: Port A mail write loads A-to-B register.
// RULE4: Port B mail write loads B-to-A register.
// RULE5: Accepted mail write drives full flag low.
// RULE6: Writes ignored while full flag is low.
// RULE7: Outputs show FIFO or mail per select; Port A shows zero when its mail select is low.
// RULE8: Port B mail read sets A-to-B flag high.
// RULE9: Port A mail read sets B-to-A flag high.
// RULE10: Reading mail never alters stored word.
// RULE11: Endian choice never reorders mail lanes.
// RULE12: Port B FIFO reads are 36/18/9 bits wide.
// RULE13: Width decode from bus-match and width select.
// RULE14: Keep size select levels static after reset.
// RULE15: Width and endian take effect at reset end.
// RULE16: Endian level latched on master reset release.
// RULE17: Big-endian first piece most significant; long ignores.
// RULE18: Byte and word piece order per endian.
// RULE19: Memory holds long words; mail unconverted.
// RULE20: Remaining pieces kept in auxiliary register.
// RULE21: Unused Port B lanes are undefined.
// RULE22: Master reset raises mail flags, restarts pieces.
`ifndef MBM_PARAMS_SVH
`define MBM_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
// ==========================================================================
`define MBM_OFF_CTRL 8'h00
`define MBM_OFF_STATUS 8'h04
`define MBM_OFF_MAIL_AB 8'h08
`define MBM_OFF_MAIL_BA 8'h0C

// ==========================================================================
// Control register fields and reset value
// ==========================================================================
`define MBM_CTRL_BUS_MATCH 0
`define MBM_CTRL_WIDTH_SEL 1
`define MBM_CTRL_ENDIAN 2
`define MBM_CTRL_RESET 3'h0

// ==========================================================================
// Status register fields
// ==========================================================================
`define MBM_ST_MAIL_ONE 0
`define MBM_ST_MAIL_TWO 1
`define MBM_ST_MODE_LSB 2
`define MBM_ST_ENDIAN 5
`define MBM_ST_PIECE_LSB 6
`define MBM_ST_READY 8

// ==========================================================================
// Lane masks and bus responses
// ==========================================================================
`define MBM_MASK_LONG 36'hFFFFFFFFF
`define MBM_MASK_WORD 36'h00003FFFF
`define MBM_MASK_BYTE 36'h0000001FF
`define MBM_RESP_OKAY 2'h0
`define MBM_RESP_SLVERR 2'h2

`endif

//--- rtl/mbm_pkg.sv
/*
  Types shared by the mailbox and bus-matching block.
  Assumes nothing of its surroundings.
*/
package mbm_pkg;

  // ========================================================================
  // Port B bus size, one-hot coded
  // ========================================================================
  typedef enum logic [2:0] {
    MBM_LONG = 3'h1,
    MBM_WORD = 3'h2,
    MBM_BYTE = 3'h4
  } mbm_width_t;

endpackage : mbm_pkg

//--- rtl/mbm_mailbox_match.sv
/*
  Mailbox pair and Port B bus-matching FIFO read path, with an AXI4-Lite
  register slave for configuration and status.
  Assumes both port clocks are synchronous level inputs sampled on aclk,
  and that the FIFO memory outside offers its head long word with a valid
  level and takes a one-cycle pop pulse.
*/
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mbm_params.svh"

module mbm_mailbox_match (
  input wire logic aclk,
  input wire logic aresetn,
  // Device master reset and ready flag.
  input wire logic master_reset_n,
  output logic full_or_input_ready,
  // Port A pins.
  input wire logic port_a_clock,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_strobe_gate,
  input wire logic port_a_mail_select,
  input wire logic [35:0] port_a_data_in,
  output logic [35:0] port_a_data_out,
  output logic port_a_data_oe,
  // Port B pins.
  input wire logic port_b_clock,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_direction,
  input wire logic port_b_strobe_gate,
  input wire logic port_b_mail_select,
  input wire logic [35:0] port_b_data_in,
  output logic [35:0] port_b_data_out,
  output logic port_b_data_oe,
  // Mail flags.
  output logic mail_one_full_n,
  output logic mail_two_full_n,
  // FIFO memory head.
  input wire logic [35:0] fifo_word,
  input wire logic fifo_word_valid,
  output logic fifo_word_pop,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mbm_pkg::*;

  // ========================================================================
  // State
  // ========================================================================
  logic [2:0] ctrl_q; // Software levels for bus match, width, endian.
  mbm_pkg::mbm_width_t mode_q; // Bus size in effect since reset end.
  logic endian_q; // Big-endian when high, latched at reset end.
  logic ready_q; // Full/input-ready flag.
  logic mrst_prev_q; // Master reset level one cycle ago.
  logic a_clk_prev_q; // Port A clock level one cycle ago.
  logic b_clk_prev_q; // Port B clock level one cycle ago.
  logic [35:0] mail_ab_q; // Mail from Port A to Port B.
  logic [35:0] mail_ba_q; // Mail from Port B to Port A.
  logic full_one_n_q; // Low while A-to-B mail is unread.
  logic full_two_n_q; // Low while B-to-A mail is unread.
  logic [35:0] aux_q; // Long word whose later pieces remain.
  logic [1:0] piece_q; // Index of the next piece to emit.
  logic [35:0] fifo_out_q; // FIFO output register.
  logic pop_q; // Pop pulse to the FIFO memory.
  logic [35:0] a_out_q; // Port A data driven out.
  logic a_oe_q; // Port A drive enable.
  logic [35:0] b_out_q; // Port B data driven out.
  logic b_oe_q; // Port B drive enable.

  // ========================================================================
  // Configuration decode
  // ========================================================================
  // Width encoding from the software levels.
  wire mbm_width_t mode_sel = !ctrl_q[`MBM_CTRL_BUS_MATCH] ? MBM_LONG : // RULE13
    (ctrl_q[`MBM_CTRL_WIDTH_SEL] ? MBM_BYTE : MBM_WORD);
  // Lanes usable under the size in effect.
  wire logic [35:0] lane_mask = (mode_q == MBM_LONG) ? `MBM_MASK_LONG :
    ((mode_q == MBM_WORD) ? `MBM_MASK_WORD : `MBM_MASK_BYTE);
  // Rising edges of master reset and the two port clocks.
  wire logic mrst_rise = master_reset_n && !mrst_prev_q;
  wire logic a_rise = port_a_clock && !a_clk_prev_q;
  wire logic b_rise = port_b_clock && !b_clk_prev_q;

  // ========================================================================
  // Port access decode
  // ========================================================================
  // Port A selected and gated on this port clock edge.
  wire logic a_sel = a_rise && !port_a_chip_select_n && port_a_strobe_gate;
  wire logic b_sel = b_rise && !port_b_chip_select_n && port_b_strobe_gate;
  wire logic a_mail_wr = a_sel && port_a_direction && port_a_mail_select; // RULE2
  wire logic a_mail_rd = a_sel && !port_a_direction && port_a_mail_select;
  wire logic b_mail_wr = b_sel && !port_b_direction && port_b_mail_select;
  wire logic b_mail_rd = b_sel && port_b_direction && port_b_mail_select;
  wire logic b_fifo_rd = b_sel && port_b_direction && !port_b_mail_select && ready_q;
  // Writes land only while the register holds no unread mail.
  wire logic ab_load = a_mail_wr && full_one_n_q; // RULE6
  wire logic ba_load = b_mail_wr && full_two_n_q; // RULE6

  // ========================================================================
  // Bus-matching piece selection
  // ========================================================================
  // A new long word is needed at piece zero; later pieces come from aux_q.
  wire logic [35:0] src_word = (piece_q == 2'h0) ? fifo_word : aux_q; // RULE20
  wire logic [8:0] byte_lane [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      // Lane g holds bits 9g+8 down to 9g.
      assign byte_lane[g] = src_word[g*9 +: 9];
    end
  endgenerate
  // Big-endian walks lanes from the top, little-endian from the bottom.
  wire logic [1:0] byte_idx = endian_q ? (2'h3 - piece_q) : piece_q; // RULE18
  wire logic word_idx = endian_q ? !piece_q[0] : piece_q[0]; // RULE17
  wire logic [17:0] word_piece = word_idx ? src_word[35:18] : src_word[17:0];
  wire logic [1:0] last_piece = (mode_q == MBM_WORD) ? 2'h1 : 2'h3;
  // A read is taken when pieces remain or memory offers a word.
  wire logic fifo_take = b_fifo_rd && (piece_q != 2'h0 || fifo_word_valid);
  wire logic fifo_new = fifo_take && (piece_q == 2'h0); // RULE19
  // Piece placed in the low lanes; unused lanes read as zero.
  wire logic [35:0] fifo_piece = (mode_q == MBM_LONG) ? src_word : // RULE12 RULE21
    ((mode_q == MBM_WORD) ? {18'h00000, word_piece} :
    {27'h0000000, byte_lane[byte_idx]});
  wire logic piece_wrap = (mode_q == MBM_LONG) || (piece_q == last_piece);

  // ========================================================================
  // Output data selection
  // ========================================================================
  // Mail passes lane for lane; endian never touches it.
  wire logic [35:0] a_out_d = port_a_mail_select ? (mail_ba_q & lane_mask) : 36'h000000000; // RULE11
  wire logic [35:0] b_out_d = port_b_mail_select ? (mail_ab_q & lane_mask) : fifo_out_q; // RULE7

  // ========================================================================
  // Edge history and configuration latch
  // ========================================================================
  // Width and endian become active at the release of master reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mrst_prev_q <= 1'b0;
      a_clk_prev_q <= 1'b1;
      b_clk_prev_q <= 1'b1;
      mode_q <= MBM_LONG;
      endian_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      mrst_prev_q <= master_reset_n;
      a_clk_prev_q <= port_a_clock;
      b_clk_prev_q <= port_b_clock;
      if (!master_reset_n) begin
        ready_q <= 1'b0;
      end else if (mrst_rise) begin
        mode_q <= mode_sel; // RULE15
        endian_q <= ctrl_q[`MBM_CTRL_ENDIAN]; // RULE16
        ready_q <= 1'b1; // RULE15
      end
    end
  end

  // ========================================================================
  // Mail registers and flags
  // ========================================================================
  // Stores only the usable lanes; reads leave contents untouched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mail_ab_q <= 36'h000000000;
      mail_ba_q <= 36'h000000000;
    end else begin
      if (ab_load) begin
        mail_ab_q <= port_a_data_in & lane_mask; // RULE1 RULE3 RULE10
      end
      if (ba_load) begin
        mail_ba_q <= port_b_data_in & lane_mask; // RULE1 RULE4
      end
    end
  end

  // A write landing in the cycle of a read keeps the flag low.
  always_ff @(posedge aclk) begin
    if (!aresetn || !master_reset_n) begin
      full_one_n_q <= 1'b1; // RULE22
      full_two_n_q <= 1'b1; // RULE22
    end else begin
      if (ab_load) begin
        full_one_n_q <= 1'b0; // RULE5
      end else if (b_mail_rd) begin
        full_one_n_q <= 1'b1; // RULE8
      end
      if (ba_load) begin
        full_two_n_q <= 1'b0; // RULE5
      end else if (a_mail_rd) begin
        full_two_n_q <= 1'b1; // RULE9
      end
    end
  end

  // ========================================================================
  // FIFO read path
  // ========================================================================
  // Splits each long word into pieces held in the auxiliary register.
  always_ff @(posedge aclk) begin
    if (!aresetn || !master_reset_n) begin
      piece_q <= 2'h0; // RULE22
      aux_q <= 36'h000000000;
      fifo_out_q <= 36'h000000000;
      pop_q <= 1'b0;
    end else begin
      pop_q <= fifo_new;
      if (fifo_new) begin
        aux_q <= fifo_word; // RULE20
      end
      if (fifo_take) begin
        fifo_out_q <= fifo_piece;
        piece_q <= piece_wrap ? 2'h0 : piece_q + 2'h1; // RULE20
      end
    end
  end

  // ========================================================================
  // Pin drivers
  // ========================================================================
  // Drives are enabled for a selected read on each port.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_out_q <= 36'h000000000;
      a_oe_q <= 1'b0;
      b_out_q <= 36'h000000000;
      b_oe_q <= 1'b0;
    end else begin
      a_out_q <= a_out_d;
      a_oe_q <= !port_a_chip_select_n && !port_a_direction;
      b_out_q <= b_out_d; // RULE7
      b_oe_q <= !port_b_chip_select_n && port_b_direction;
    end
  end

  // ========================================================================
  // AXI4-Lite slave
  // ========================================================================
  logic aw_held_q; // Write address taken, waiting for data.
  logic [7:0] aw_addr_q; // Held write address.
  logic w_held_q; // Write data taken, waiting for address.
  logic [31:0] w_data_q; // Held write data.
  logic w_strb0_q; // Held strobe of byte lane zero.
  logic awready_q; // Write address ready.
  logic wready_q; // Write data ready.
  logic bvalid_q; // Write response valid.
  logic [1:0] bresp_q; // Write response code.
  logic arready_q; // Read address ready.
  logic rvalid_q; // Read data valid.
  logic [31:0] rdata_q; // Read data.
  logic [1:0] rresp_q; // Read response code.

  // Address and data are taken independently, in either order.
  wire logic aw_take = s_axi_awvalid && awready_q;
  wire logic w_take = s_axi_wvalid && wready_q;
  wire logic aw_have = aw_held_q || aw_take;
  wire logic w_have = w_held_q || w_take;
  wire logic do_write = aw_have && w_have && !bvalid_q;
  wire logic [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_q;
  wire logic [31:0] wr_data = w_take ? s_axi_wdata : w_data_q;
  wire logic wr_strb0 = w_take ? s_axi_wstrb[0] : w_strb0_q;
  wire logic wr_ctrl = ({wr_addr[7:2], 2'h0} == `MBM_OFF_CTRL);
  wire logic aw_held_d = aw_have && !do_write;
  wire logic w_held_d = w_have && !do_write;
  wire logic bvalid_d = do_write || (bvalid_q && !s_axi_bready);
  wire logic ar_take = s_axi_arvalid && arready_q;
  wire logic rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
  wire logic [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
  // Status word: mail flags, size, endian, piece index and ready.
  wire logic [31:0] status_word = {23'h000000, ready_q, piece_q, endian_q, mode_q,
    full_two_n_q, full_one_n_q};
  wire logic rd_hit = (rd_addr == `MBM_OFF_CTRL) || (rd_addr == `MBM_OFF_STATUS) ||
    (rd_addr == `MBM_OFF_MAIL_AB) || (rd_addr == `MBM_OFF_MAIL_BA);
  // Mail words show their low 32 lanes; reading them has no side effect.
  wire logic [31:0] rd_word = (rd_addr == `MBM_OFF_CTRL) ? {29'h00000000, ctrl_q} :
    (rd_addr == `MBM_OFF_STATUS) ? status_word :
    (rd_addr == `MBM_OFF_MAIL_AB) ? mail_ab_q[31:0] :
    (rd_addr == `MBM_OFF_MAIL_BA) ? mail_ba_q[31:0] : 32'h00000000;

  // Write channel bookkeeping and control register update.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `MBM_RESP_OKAY;
      ctrl_q <= `MBM_CTRL_RESET;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= wr_addr;
      w_held_q <= w_held_d;
      w_data_q <= wr_data;
      w_strb0_q <= wr_strb0;
      awready_q <= !aw_held_d;
      wready_q <= !w_held_d;
      bvalid_q <= bvalid_d;
      if (do_write) begin
        bresp_q <= wr_ctrl ? `MBM_RESP_OKAY : `MBM_RESP_SLVERR;
        if (wr_ctrl && wr_strb0) begin
          ctrl_q <= wr_data[2:0];
        end
      end
    end
  end

  // Read channel: one read in flight, answered the cycle after it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `MBM_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `MBM_RESP_OKAY : `MBM_RESP_SLVERR;
      end
    end
  end

  // ========================================================================
  // Output ports
  // ========================================================================
  assign full_or_input_ready = ready_q;
  assign port_a_data_out = a_out_q;
  assign port_a_data_oe = a_oe_q;
  assign port_b_data_out = b_out_q;
  assign port_b_data_oe = b_oe_q;
  assign mail_one_full_n = full_one_n_q;
  assign mail_two_full_n = full_two_n_q;
  assign fifo_word_pop = pop_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;

  // ========================================================================
  // Assertions
  // ========================================================================
  a_mail_ab_load: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    ab_load && master_reset_n |=> !full_one_n_q && mail_ab_q == $past(port_a_data_in & lane_mask))
    else $error("A-to-B mail not loaded.");
  a_mail_ba_load: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    ba_load && master_reset_n |=> !full_two_n_q && mail_ba_q == $past(port_b_data_in & lane_mask))
    else $error("B-to-A mail not loaded.");
  a_mail_lockout: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    (!full_one_n_q && a_mail_wr) |=> $stable(mail_ab_q))
    else $error("Write changed unread mail.");
  a_flag_one_up: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    (b_mail_rd && !ab_load) |=> full_one_n_q)
    else $error("A-to-B flag not raised by read.");
  a_flag_two_up: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
    (a_mail_rd && !ba_load) |=> full_two_n_q)
    else $error("B-to-A flag not raised by read.");
  a_mail_read_keep: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
    (!ab_load && !ba_load) |=> ($stable(mail_ab_q) && $stable(mail_ba_q)))
    else $error("Mail changed without write.");
  a_port_b_mux: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
    port_b_mail_select |=> port_b_data_out == $past(mail_ab_q & lane_mask))
    else $error("Port B not showing mail.");
  a_width_decode: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
    mrst_rise |=> (mode_q == ($past(ctrl_q[0]) ? ($past(ctrl_q[1]) ? MBM_BYTE : MBM_WORD)
    : MBM_LONG)) && ready_q)
    else $error("Width not decoded at reset end.");
  a_byte_first: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
    (fifo_new && mode_q == MBM_BYTE && endian_q && master_reset_n)
    |=> fifo_out_q[8:0] == $past(fifo_word[35:27]))
    else $error("Big-endian first byte wrong.");
  a_reset_flags: assert property (@(posedge aclk) disable iff (!aresetn) // RULE22
    !master_reset_n |=> (full_one_n_q && full_two_n_q && piece_q == 2'h0 && !ready_q))
    else $error("Master reset did not clear state.");

endmodule : mbm_mailbox_match

//--- bench/mbm_fifo_head_model.sv
/*
  FIFO memory head model: offers one long word with a valid level.
  Assumes the bench loads a word and the design pops it with a pulse.
*/
`timescale 1ns/1ps
module mbm_fifo_head_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [35:0] load_word,
  input wire logic fifo_word_pop,
  output logic [35:0] fifo_word,
  output logic fifo_word_valid
);
  // ==========================================================================
  // Head word storage
  // ==========================================================================
  // A popped word is inverted so that stale data never passes for fresh data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      fifo_word <= 36'h0;
      fifo_word_valid <= 1'b0;
    end else if (load) begin
      fifo_word <= load_word;
      fifo_word_valid <= 1'b1;
    end else if (fifo_word_pop) begin
      fifo_word <= ~fifo_word;
      fifo_word_valid <= 1'b0;
    end
  end
endmodule : mbm_fifo_head_model

//--- bench/tb_mailbox_and_bus_matching_read.sv
/*
  Bench for the mailbox pair and Port B bus-matching read path.
  Assumes the FIFO head model stands in for the memory behind Port B.
*/
`timescale 1ns/1ps
`include "mbm_params.svh"
module tb_mailbox_and_bus_matching_read;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic aclk = 0, aresetn = 0, master_reset_n = 0, load = 0;
  logic [35:0] load_word = 0;
  logic [1:0] pclk = 0, pcs_n = 2'h3, pdir = 0, pgate = 0, pmail = 0;
  logic [1:0][35:0] pdin = 0;
  wire [1:0][35:0] pdout;
  wire [1:0] mfull_n, poe, s_axi_bresp, s_axi_rresp;
  wire [35:0] fifo_word;
  wire fifo_word_valid, fifo_word_pop, full_or_input_ready;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  wire [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int checks = 0, n_mismatch = 0, cyc = 0;
  // Size and endian levels stay fixed between master resets.
  logic [2:0] modes [5] = '{3'h4, 3'h1, 3'h5, 3'h7, 3'h3};

  mbm_fifo_head_model u_head (.aclk, .aresetn, .load, .load_word, .fifo_word_pop, .fifo_word,
    .fifo_word_valid);
  mbm_mailbox_match dut (.aclk, .aresetn, .master_reset_n, .full_or_input_ready,
    .port_a_clock(pclk[0]), .port_a_chip_select_n(pcs_n[0]), .port_a_direction(pdir[0]),
    .port_a_strobe_gate(pgate[0]), .port_a_mail_select(pmail[0]), .port_a_data_in(pdin[0]),
    .port_a_data_out(pdout[0]), .port_a_data_oe(poe[0]),
    .port_b_clock(pclk[1]), .port_b_chip_select_n(pcs_n[1]), .port_b_direction(pdir[1]),
    .port_b_strobe_gate(pgate[1]), .port_b_mail_select(pmail[1]), .port_b_data_in(pdin[1]),
    .port_b_data_out(pdout[1]), .port_b_data_oe(poe[1]),
    .mail_one_full_n(mfull_n[0]), .mail_two_full_n(mfull_n[1]), .fifo_word, .fifo_word_valid,
    .fifo_word_pop, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ==========================================================================
  // Clock, timeout and tasks
  // ==========================================================================
  // The 40 MHz clock toggles every half period.
  initial forever #12.5 aclk = ~aclk;

  // A hang counts as a mismatch and ends the run.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // Compares a seen value with the expected one.
  task automatic chk(input string s, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  // One AXI4-Lite write; each channel is released once taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit dn;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    dn = 0;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        dn = 1;
      end
    end
  endtask : axw

  // One AXI4-Lite read.
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit dn;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    dn = 0;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        dn = 1;
      end
    end
  endtask : axr

  // One port transfer: controls first, then a single port clock rise.
  task automatic port_op(input int p, input logic wr, input logic mb, input logic [35:0] d);
    @(posedge aclk);
    pcs_n[p] <= 1'b0;
    pgate[p] <= 1'b1;
    pdir[p] <= wr ^ p[0];
    pmail[p] <= mb;
    pdin[p] <= d;
    @(posedge aclk);
    pclk[p] <= 1'b1;
    @(posedge aclk);
    pclk[p] <= 1'b0;
    pgate[p] <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : port_op

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [2:0] c;
    int w, n, sh;
    logic [35:0] mk, x;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`MBM_OFF_CTRL, d, r);
    chk("ctrl reset", {4'h0, d}, 36'h0);
    axw(8'h10, 32'h7, r);
    chk("unmapped write", {34'h0, r}, 36'h2);
    axr(8'h10, d, r);
    chk("unmapped read", {34'h0, r}, 36'h2);
    // Each size, and both endian choices for word and byte, sees FIFO pieces and mail both ways.
    foreach (modes[i]) begin
      c = modes[i];
      axw(`MBM_OFF_CTRL, {29'h0, c}, r);
      master_reset_n <= 1'b0;
      repeat (3) @(posedge aclk);
      master_reset_n <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("ready and flags", {33'h0, full_or_input_ready, mfull_n}, 36'h7);
      w = c[0] ? (c[1] ? 9 : 18) : 36;
      n = 36 / w;
      mk = (36'h1 << w) - 36'h1;
      axr(`MBM_OFF_STATUS, d, r);
      chk("status size", {32'h0, d[8], d[4:2]}, {32'h0, 1'b1, w == 9, w == 18, w == 36});
      x = 36'hA5C3E1F97 ^ {33'h0, c};
      load_word <= x;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      for (int k = 0; k < n; k++) begin
        port_op(1, 1'b0, 1'b0, 36'h0);
        sh = c[2] ? 36 - w * (k + 1) : w * k;
        chk("fifo piece", pdout[1] & mk, (x >> sh) & mk);
      end
      chk("word popped", {35'h0, fifo_word_valid}, 36'h0);
      port_op(0, 1'b1, 1'b1, x);
      port_op(0, 1'b1, 1'b1, ~x);
      chk("mail one flag", {35'h0, mfull_n[0]}, 36'h0);
      port_op(1, 1'b0, 1'b1, 36'h0);
      chk("mail to b", pdout[1] & mk, x & mk);
      chk("mail one read", {34'h0, poe[1], mfull_n[0]}, 36'h3);
      port_op(1, 1'b0, 1'b1, 36'h0);
      chk("mail to b again", pdout[1] & mk, x & mk);
      port_op(1, 1'b1, 1'b1, ~x);
      chk("mail two flag", {35'h0, mfull_n[1]}, 36'h0);
      port_op(0, 1'b0, 1'b1, 36'h0);
      chk("mail to a", pdout[0] & mk, ~x & mk);
      chk("mail two read", {34'h0, poe[0], mfull_n[1]}, 36'h3);
      // Mail left pending here must have its flag raised by the next master reset; the stored word stays.
      port_op(0, 1'b1, 1'b1, x);
    end
    results();
  end
endmodule : tb_mailbox_and_bus_matching_read
